// *** cid_map.vh ***
// Timing counts, field codes and flag-action codes for the instruction decoder
// Notes on behaviour
// - S bit sign-extends one immediate byte when W is set
// - W bit picks byte or word operand
// - Mode 11 reads register selectors by width
// - Memory address from base/index plus displacement
// - Location 110 mode 00 is direct address
// - Segment selector decodes to four segments
// - Each flag gets its encoded update action
// - Register move: two clocks, two bytes
// - Store 7/11 clocks, load 10/14
// - Short register-immediate load: four clocks
// - Block move nine plus 8n/16n
// - Block compare seven plus 14n/22n
// - Unrepeated block move, compare or port string uses single-execution count
// - Port input 9/13 immediate, 8/12 data
// - Port output 8/12 both forms
// - Block port transfer nine plus 8n/16n
// - Packed decimal strings seven plus 19n
// - Immediate group operation from bits 5:3
// - Logical ops clear carry and overflow
// - Timing pair: byte first, word second
// - Add four clocks per missing byte
`ifndef CID_MAP_VH
`define CID_MAP_VH
`define CID_F_N 3'h0
`define CID_F_C0 3'h1
`define CID_F_S1 3'h2
`define CID_F_X 3'h3
`define CID_F_U 3'h4
`define CID_F_R 3'h5
`define CID_T_MISS 10'h004
`define CID_T_PFX 10'h002
`define CID_T_MOVRR 24'h00_0002
`define CID_T_ST_B 24'h00_0007
`define CID_T_ST_W 24'h00_000B
`define CID_T_LD_B 24'h00_000A
`define CID_T_LD_W 24'h00_000E
`define CID_T_MOVRI 24'h00_0004
`define CID_T_MOV_BASE 24'h00_0009
`define CID_T_MOV_PB 24'h00_0008
`define CID_T_MOV_PW 24'h00_0010
`define CID_T_MOV_1B 24'h00_0009
`define CID_T_MOV_1W 24'h00_0011
`define CID_T_CMP_BASE 24'h00_0007
`define CID_T_CMP_PB 24'h00_000E
`define CID_T_CMP_PW 24'h00_0016
`define CID_T_CMP_1B 24'h00_000D
`define CID_T_CMP_1W 24'h00_0015
`define CID_T_INI_B 24'h00_0009
`define CID_T_INI_W 24'h00_000D
`define CID_T_IO_B 24'h00_0008
`define CID_T_IO_W 24'h00_000C
`define CID_T_BIO_BASE 24'h00_0009
`define CID_T_BIO_PB 24'h00_0008
`define CID_T_BIO_PW 24'h00_0010
`define CID_T_BIO_1B 24'h00_000A
`define CID_T_BIO_1W 24'h00_0012
`define CID_T_BCD_BASE 24'h00_0007
`define CID_T_BCD_PU 24'h00_0013
`define CID_T_ADJ 24'h00_0003
`define CID_T_B2D 24'h00_000F
`define CID_T_D2B 24'h00_0007
`define CID_T_ALU_RI 24'h00_0004
`define CID_T_ALU_MB 24'h00_000F
`define CID_T_ALU_MW 24'h00_0017
`define CID_T_ACMP_MB 24'h00_000C
`define CID_T_ACMP_MW 24'h00_0010
`define CID_T_TST_RR 24'h00_0002
`define CID_T_TST_MB 24'h00_0009
`define CID_T_TST_MW 24'h00_000D
`endif

// *** cid_decoder.v ***
// Byte-serial instruction decoder with clock-count and flag-action output
`timescale 1ns/1ps
`default_nettype none
`include "cid_map.vh"
module cid_decoder (
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_ce,
	input  wire        i_byte_valid,
	input  wire [7:0]  i_byte,
	input  wire        i_byte_queued,
	input  wire [15:0] i_iter_count,
	output reg         o_hdr_valid,
	output reg  [4:0]  o_op,
	output reg  [2:0]  o_alu,
	output reg         o_wide,
	output reg  [3:0]  o_ea,
	output reg  [3:0]  o_len,
	output reg  [3:0]  o_reg_a,
	output reg  [3:0]  o_reg_b,
	output reg  [3:0]  o_seg,
	output reg  [2:0]  o_rep,
	output reg         o_no_write,
	output reg         o_done,
	output reg  [23:0] o_clocks,
	output reg  [15:0] o_disp,
	output reg  [15:0] o_imm,
	output reg  [17:0] o_flags,
	output reg  [3:0]  o_bytes
);
	// One-hot decode states
	localparam [3:0] S_OP    = 4'h1;
	localparam [3:0] S_OP2   = 4'h2;
	localparam [3:0] S_MODRM = 4'h4;
	localparam [3:0] S_DATA  = 4'h8;
	// Operation codes
	localparam [4:0] OP_NONE  = 5'h00;
	localparam [4:0] OP_MOVRR = 5'h01;
	localparam [4:0] OP_MOVST = 5'h02;
	localparam [4:0] OP_MOVLD = 5'h03;
	localparam [4:0] OP_MOVRI = 5'h04;
	localparam [4:0] OP_BMOV  = 5'h05;
	localparam [4:0] OP_BCMP  = 5'h06;
	localparam [4:0] OP_INI   = 5'h07;
	localparam [4:0] OP_IND   = 5'h08;
	localparam [4:0] OP_OUTI  = 5'h09;
	localparam [4:0] OP_OUTD  = 5'h0A;
	localparam [4:0] OP_BIN   = 5'h0B;
	localparam [4:0] OP_BOUT  = 5'h0C;
	localparam [4:0] OP_BADD  = 5'h0D;
	localparam [4:0] OP_BSUB  = 5'h0E;
	localparam [4:0] OP_BCMPS = 5'h0F;
	localparam [4:0] OP_ADJA  = 5'h10;
	localparam [4:0] OP_ADJS  = 5'h11;
	localparam [4:0] OP_CVBD  = 5'h12;
	localparam [4:0] OP_CVDB  = 5'h13;
	localparam [4:0] OP_ALUI  = 5'h14;
	localparam [4:0] OP_TEST  = 5'h15;
	localparam [4:0] OP_ILL   = 5'h16;
	// Repeat prefix kinds
	localparam [2:0] REP_C  = 3'h1;
	localparam [2:0] REP_NC = 3'h2;
	localparam [2:0] REP_E  = 3'h3;
	localparam [2:0] REP_NE = 3'h4;

	// Addressing kind: 0 register, 1..8 location table order, 9 direct
	function [3:0] ea_of;
		input [1:0] md;
		input [2:0] rm;
		begin
			if (md == 2'h3) begin
				ea_of = 4'h0;
			end else if (md == 2'h0 && rm == 3'h6) begin
				ea_of = 4'h9;
			end else begin
				ea_of = {1'b0, rm} + 4'h1;
			end
		end
	endfunction

	// Displacement bytes following the mode byte
	function [1:0] disp_cnt;
		input [1:0] md;
		input [2:0] rm;
		begin
			if (md == 2'h1) begin
				disp_cnt = 2'h1;
			end else if (md == 2'h2 || (md == 2'h0 && rm == 3'h6)) begin
				disp_cnt = 2'h2;
			end else begin
				disp_cnt = 2'h0;
			end
		end
	endfunction

	// Segment selector to one-hot {data0, stack, program, data1}
	function [3:0] seg_of;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: seg_of = 4'h1;
				2'h1: seg_of = 4'h2;
				2'h2: seg_of = 4'h4;
				default: seg_of = 4'h8;
			endcase
		end
	endfunction

	// Byte/word pick from a timing pair
	function [23:0] pair;
		input        w;
		input [23:0] tb;
		input [23:0] tw;
		begin
			pair = w ? tw : tb;
		end
	endfunction

	// Execution clocks, queue assumed full
	function [23:0] op_clk;
		input [4:0]  op;
		input        w;
		input        mem;
		input [2:0]  alu;
		input        rep;
		input [15:0] n;
		reg   [23:0] nn;
		reg   [23:0] nh;
		begin
			nn = {8'h00, n};
			nh = {9'h000, n[15:1]};
			case (op)
				OP_MOVRR: op_clk = `CID_T_MOVRR;
				OP_MOVST: op_clk = pair(w, `CID_T_ST_B, `CID_T_ST_W);
				OP_MOVLD: op_clk = pair(w, `CID_T_LD_B, `CID_T_LD_W);
				OP_MOVRI: op_clk = `CID_T_MOVRI;
				// Unrepeated block moves, compares and port transfers use the single figure
				OP_BMOV: op_clk = rep ?
					`CID_T_MOV_BASE + pair(w, `CID_T_MOV_PB, `CID_T_MOV_PW) * nn :
					pair(w, `CID_T_MOV_1B, `CID_T_MOV_1W);
				OP_BCMP: op_clk = rep ?
					`CID_T_CMP_BASE + pair(w, `CID_T_CMP_PB, `CID_T_CMP_PW) * nn :
					pair(w, `CID_T_CMP_1B, `CID_T_CMP_1W);
				OP_BIN, OP_BOUT: op_clk = rep ?
					`CID_T_BIO_BASE + pair(w, `CID_T_BIO_PB, `CID_T_BIO_PW) * nn :
					pair(w, `CID_T_BIO_1B, `CID_T_BIO_1W);
				OP_INI: op_clk = pair(w, `CID_T_INI_B, `CID_T_INI_W);
				OP_IND: op_clk = pair(w, `CID_T_IO_B, `CID_T_IO_W);
				OP_OUTI, OP_OUTD: op_clk = pair(w, `CID_T_IO_B, `CID_T_IO_W);
				// Unit count is half the digit count
				OP_BADD, OP_BSUB, OP_BCMPS:
					op_clk = `CID_T_BCD_BASE + `CID_T_BCD_PU * nh;
				OP_ADJA, OP_ADJS: op_clk = `CID_T_ADJ;
				OP_CVBD: op_clk = `CID_T_B2D;
				OP_CVDB: op_clk = `CID_T_D2B;
				OP_ALUI: begin
					if (!mem) begin
						op_clk = `CID_T_ALU_RI;
					end else if (alu == 3'h7) begin
						op_clk = pair(w, `CID_T_ACMP_MB, `CID_T_ACMP_MW);
					end else begin
						op_clk = pair(w, `CID_T_ALU_MB, `CID_T_ALU_MW);
					end
				end
				OP_TEST: op_clk = mem ? pair(w, `CID_T_TST_MB, `CID_T_TST_MW) :
					`CID_T_TST_RR;
				default: op_clk = 24'h00_0000;
			endcase
		end
	endfunction

	// Flag actions, three bits each: aux carry, carry, overflow, parity, sign, zero
	function [17:0] flg_of;
		input [4:0] op;
		input [2:0] alu;
		reg         lg;
		begin
			lg = (alu == 3'h1) || (alu == 3'h4) || (alu == 3'h6);
			case (op)
				OP_BCMP: flg_of = {6{`CID_F_X}};
				OP_ALUI: flg_of = lg ?
					{`CID_F_U, `CID_F_C0, `CID_F_C0, {3{`CID_F_X}}} :
					{6{`CID_F_X}};
				OP_TEST: flg_of = {`CID_F_U, `CID_F_C0, `CID_F_C0, {3{`CID_F_X}}};
				OP_BADD, OP_BSUB, OP_BCMPS: flg_of =
					{`CID_F_U, `CID_F_X, {3{`CID_F_U}}, `CID_F_X};
				OP_ADJA, OP_ADJS: flg_of =
					{`CID_F_X, `CID_F_X, `CID_F_U, {3{`CID_F_X}}};
				OP_CVBD, OP_CVDB: flg_of = {{3{`CID_F_U}}, {3{`CID_F_X}}};
				default: flg_of = {6{`CID_F_N}};
			endcase
		end
	endfunction

	// Decode state
	reg [3:0]  state_r, state_nxt;     // One-hot state
	reg [7:0]  opc_r, opc_nxt;         // First opcode byte
	reg [4:0]  op_r, op_nxt;           // Operation
	reg [2:0]  alu_r, alu_nxt;         // Immediate-group operation
	reg        w_r, w_nxt;             // Width bit
	reg        s_r, s_nxt;             // Sign-extend bit
	reg [1:0]  md_r, md_nxt;           // Addressing kind
	reg [2:0]  rg_r, rg_nxt;           // Register field
	reg [2:0]  rm_r, rm_nxt;           // Location field
	reg [2:0]  rep_r, rep_nxt;         // Pending repeat prefix
	reg [1:0]  nd_r, nd_nxt;           // Displacement bytes
	reg [1:0]  ni_r, ni_nxt;           // Immediate bytes
	reg [2:0]  pos_r, pos_nxt;         // Data byte index
	reg [3:0]  got_r, got_nxt;         // Bytes taken so far
	reg [9:0]  xtra_r, xtra_nxt;       // Prefix and fetch penalty clocks
	reg [15:0] dsp_r, dsp_nxt;         // Raw displacement
	reg [15:0] imm_r, imm_nxt;         // Raw immediate
	reg        hdr;                    // Final opcode byte, or mode byte if any, taken
	reg        fin;                    // Last instruction byte taken
	reg [2:0]  k;                      // Index into immediate bytes
	wire       take = i_ce & i_byte_valid;

	// Next-state decode of the incoming byte
	always @* begin
		state_nxt = state_r;
		opc_nxt   = opc_r;
		op_nxt    = op_r;
		alu_nxt   = alu_r;
		w_nxt     = w_r;
		s_nxt     = s_r;
		md_nxt    = md_r;
		rg_nxt    = rg_r;
		rm_nxt    = rm_r;
		rep_nxt   = rep_r;
		nd_nxt    = nd_r;
		ni_nxt    = ni_r;
		pos_nxt   = pos_r;
		got_nxt   = got_r;
		xtra_nxt  = xtra_r;
		dsp_nxt   = dsp_r;
		imm_nxt   = imm_r;
		hdr       = 1'b0;
		fin       = 1'b0;
		k         = pos_r - {1'b0, nd_r};
		if (i_byte_valid) begin
			got_nxt  = got_r + 4'h1;
			// Byte fetched late costs extra
			xtra_nxt = xtra_r + (i_byte_queued ? 10'h000 : `CID_T_MISS);
			case (state_r)
				S_OP: begin
					opc_nxt = i_byte;
					w_nxt   = i_byte[0];
					s_nxt   = 1'b0;
					md_nxt  = 2'h3;
					nd_nxt  = 2'h0;
					ni_nxt  = 2'h0;
					pos_nxt = 3'h0;
					alu_nxt = 3'h0;
					dsp_nxt = 16'h0000;
					imm_nxt = 16'h0000;
					hdr     = 1'b1;
					fin     = 1'b1;
					if (i_byte == 8'h65 || i_byte == 8'h64 ||
						i_byte == 8'hF3 || i_byte == 8'hF2) begin
						// Prefix joins the next instruction
						hdr      = 1'b0;
						fin      = 1'b0;
						xtra_nxt = xtra_nxt + `CID_T_PFX;
						if (i_byte == 8'h65) begin
							rep_nxt = REP_C;
						end else if (i_byte == 8'h64) begin
							rep_nxt = REP_NC;
						end else if (i_byte == 8'hF3) begin
							rep_nxt = REP_E;
						end else begin
							rep_nxt = REP_NE;
						end
					end else if ((i_byte & 8'hFC) == 8'h88) begin
						op_nxt    = i_byte[1] ? OP_MOVLD : OP_MOVST;
						state_nxt = S_MODRM;
						hdr       = 1'b0;
						fin       = 1'b0;
					end else if ((i_byte & 8'hFE) == 8'h84) begin
						op_nxt    = OP_TEST;
						state_nxt = S_MODRM;
						hdr       = 1'b0;
						fin       = 1'b0;
					end else if ((i_byte & 8'hFC) == 8'h80) begin
						op_nxt    = OP_ALUI;
						s_nxt     = i_byte[1];
						state_nxt = S_MODRM;
						hdr       = 1'b0;
						fin       = 1'b0;
					end else if ((i_byte & 8'hF0) == 8'hB0) begin
						op_nxt    = OP_MOVRI;
						w_nxt     = i_byte[3];
						rg_nxt    = i_byte[2:0];
						ni_nxt    = i_byte[3] ? 2'h2 : 2'h1;
						state_nxt = S_DATA;
						fin       = 1'b0;
					end else if ((i_byte & 8'hFC) == 8'hE4) begin
						op_nxt    = i_byte[1] ? OP_OUTI : OP_INI;
						ni_nxt    = 2'h1;
						state_nxt = S_DATA;
						fin       = 1'b0;
					end else if ((i_byte & 8'hFC) == 8'hEC) begin
						op_nxt = i_byte[1] ? OP_OUTD : OP_IND;
					end else if ((i_byte & 8'hFC) == 8'hA4) begin
						op_nxt = i_byte[1] ? OP_BCMP : OP_BMOV;
					end else if ((i_byte & 8'hFC) == 8'h6C) begin
						op_nxt = i_byte[1] ? OP_BOUT : OP_BIN;
					end else if (i_byte == 8'h27 || i_byte == 8'h2F) begin
						op_nxt = i_byte[3] ? OP_ADJS : OP_ADJA;
						w_nxt  = 1'b0;
					end else if (i_byte == 8'h0F || i_byte == 8'hD4 ||
						i_byte == 8'hD5) begin
						state_nxt = S_OP2;
						hdr       = 1'b0;
						fin       = 1'b0;
					end else begin
						op_nxt = OP_ILL;
					end
				end
				S_OP2: begin
					w_nxt     = 1'b0;
					hdr       = 1'b1;
					fin       = 1'b1;
					state_nxt = S_OP;
					if (opc_r == 8'h0F && i_byte == 8'h20) begin
						op_nxt = OP_BADD;
					end else if (opc_r == 8'h0F && i_byte == 8'h22) begin
						op_nxt = OP_BSUB;
					end else if (opc_r == 8'h0F && i_byte == 8'h26) begin
						op_nxt = OP_BCMPS;
					end else if (opc_r == 8'hD4 && i_byte == 8'h0A) begin
						op_nxt = OP_CVBD;
					end else if (opc_r == 8'hD5 && i_byte == 8'h0A) begin
						op_nxt = OP_CVDB;
					end else begin
						op_nxt = OP_ILL;
					end
				end
				S_MODRM: begin
					md_nxt  = i_byte[7:6];
					rg_nxt  = i_byte[5:3];
					rm_nxt  = i_byte[2:0];
					alu_nxt = (op_r == OP_ALUI) ? i_byte[5:3] : 3'h0;
					nd_nxt  = disp_cnt(i_byte[7:6], i_byte[2:0]);
					if (op_r == OP_ALUI) begin
						ni_nxt = (w_r & ~s_r) ? 2'h2 : 2'h1;
					end
					if ((op_r == OP_MOVLD || op_r == OP_MOVST) && i_byte[7:6] == 2'h3) begin
						op_nxt = OP_MOVRR;
					end
					hdr = 1'b1;
					if (nd_nxt == 2'h0 && ni_nxt == 2'h0) begin
						fin       = 1'b1;
						state_nxt = S_OP;
					end else begin
						state_nxt = S_DATA;
					end
				end
				S_DATA: begin
					pos_nxt = pos_r + 3'h1;
					// Low byte first for both fields
					if (pos_r < {1'b0, nd_r}) begin
						if (pos_r == 3'h0) begin
							dsp_nxt[7:0] = i_byte;
						end else begin
							dsp_nxt[15:8] = i_byte;
						end
					end else if (k == 3'h0) begin
						imm_nxt[7:0] = i_byte;
					end else begin
						imm_nxt[15:8] = i_byte;
					end
					if (pos_nxt == {1'b0, nd_r} + {1'b0, ni_r}) begin
						fin       = 1'b1;
						state_nxt = S_OP;
					end
				end
				default: begin
					state_nxt = S_OP;
				end
			endcase
		end
	end

	// State and output registers; clock enable freezes everything
	always @(posedge i_clk) begin
		if (i_reset) begin
			state_r     <= S_OP;
			opc_r       <= 8'h00;
			op_r        <= OP_NONE;
			alu_r       <= 3'h0;
			w_r         <= 1'b0;
			s_r         <= 1'b0;
			md_r        <= 2'h0;
			rg_r        <= 3'h0;
			rm_r        <= 3'h0;
			rep_r       <= 3'h0;
			nd_r        <= 2'h0;
			ni_r        <= 2'h0;
			pos_r       <= 3'h0;
			got_r       <= 4'h0;
			xtra_r      <= 10'h000;
			dsp_r       <= 16'h0000;
			imm_r       <= 16'h0000;
			o_hdr_valid <= 1'b0;
			o_op        <= OP_NONE;
			o_alu       <= 3'h0;
			o_wide      <= 1'b0;
			o_ea        <= 4'h0;
			o_len       <= 4'h0;
			o_reg_a     <= 4'h0;
			o_reg_b     <= 4'h0;
			o_seg       <= 4'h0;
			o_rep       <= 3'h0;
			o_no_write  <= 1'b0;
			o_done      <= 1'b0;
			o_clocks    <= 24'h00_0000;
			o_disp      <= 16'h0000;
			o_imm       <= 16'h0000;
			o_flags     <= 18'h0_0000;
			o_bytes     <= 4'h0;
		end else if (i_ce) begin
			state_r     <= state_nxt;
			opc_r       <= opc_nxt;
			op_r        <= op_nxt;
			alu_r       <= alu_nxt;
			w_r         <= w_nxt;
			s_r         <= s_nxt;
			md_r        <= md_nxt;
			rg_r        <= rg_nxt;
			rm_r        <= rm_nxt;
			nd_r        <= nd_nxt;
			ni_r        <= ni_nxt;
			pos_r       <= pos_nxt;
			dsp_r       <= dsp_nxt;
			imm_r       <= imm_nxt;
			// Per-instruction accumulators restart after the last byte
			rep_r       <= fin ? 3'h0 : rep_nxt;
			got_r       <= fin ? 4'h0 : got_nxt;
			xtra_r      <= fin ? 10'h000 : xtra_nxt;
			o_hdr_valid <= take & hdr;
			o_done      <= take & fin;
			// Early view, one edge after the final opcode byte, or the mode byte when there is one
			if (take & hdr) begin
				o_op       <= op_nxt;
				o_alu      <= alu_nxt;
				o_wide     <= w_nxt;
				o_ea       <= ea_of(md_nxt, rm_nxt);
				o_len      <= got_nxt + {2'h0, nd_nxt} + {2'h0, ni_nxt};
				o_reg_a    <= {w_nxt, rg_nxt};
				o_reg_b    <= {w_nxt, rm_nxt};
				o_seg      <= seg_of(rg_nxt[1:0]);
				o_rep      <= rep_nxt;
				o_no_write <= (op_nxt == OP_TEST) || (op_nxt == OP_BCMP) ||
					(op_nxt == OP_BCMPS) || (op_nxt == OP_ALUI && alu_nxt == 3'h7);
				o_flags    <= flg_of(op_nxt, alu_nxt);
			end
			// Full result after the last byte
			if (take & fin) begin
				o_bytes  <= got_nxt;
				o_clocks <= op_clk(op_nxt, w_nxt, md_nxt != 2'h3, alu_nxt,
					rep_nxt != 3'h0, i_iter_count) + {14'h0000, xtra_nxt};
				o_disp   <= (nd_nxt == 2'h1) ? {{8{dsp_nxt[7]}}, dsp_nxt[7:0]} :
					dsp_nxt;
				o_imm    <= (ni_nxt == 2'h1) ?
					((s_nxt & w_nxt) ? {{8{imm_nxt[7]}}, imm_nxt[7:0]} :
					{8'h00, imm_nxt[7:0]}) : imm_nxt;
			end
		end
	end
endmodule
`default_nettype wire

// *** cid_decoder_asserts.sv ***
// Concurrent checks on the decoder's result outputs
`timescale 1ns/1ps
`default_nettype none
module cid_decoder_asserts (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        o_hdr_valid,
	input wire logic        o_done,
	input wire logic        o_wide,
	input wire logic        o_no_write,
	input wire logic [4:0]  o_op,
	input wire logic [2:0]  o_alu,
	input wire logic [3:0]  o_ea,
	input wire logic [3:0]  o_len,
	input wire logic [3:0]  o_reg_a,
	input wire logic [3:0]  o_reg_b,
	input wire logic [3:0]  o_seg,
	input wire logic [2:0]  o_rep,
	input wire logic [23:0] o_clocks,
	input wire logic [17:0] o_flags
);
	// One domain; reset silences every check
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Unprefixed result; missing bytes add 4, so counts are checked modulo 4
	wire done_np = o_done && o_rep == 3'h0;

	AST_RR_MOVE: assert property (done_np && o_op == 5'h01 |->
		o_clocks[1:0] == 2'h2 && o_flags == 18'h0_0000)
		else $error("register move count or flags wrong");
	AST_REG_SEL: assert property (o_hdr_valid && o_op == 5'h01 |-> o_ea == 4'h0)
		else $error("register move not in register mode");
	AST_IMM_LEN: assert property (o_hdr_valid && o_op == 5'h04 |->
		o_len == {3'h0, o_wide} + 4'h2)
		else $error("immediate load length wrong");
	AST_DIRECT: assert property (o_hdr_valid && o_ea == 4'h9 |-> o_reg_b[2:0] == 3'h6)
		else $error("direct address from wrong location");
	AST_SEG: assert property (o_hdr_valid |-> $onehot(o_seg))
		else $error("segment select not one-hot");
	AST_BLK_CMP: assert property (o_done && o_op == 5'h06 |-> o_flags == 18'h1_B6DB)
		else $error("block compare flags wrong");
	AST_IO_OUT: assert property (done_np && (o_op == 5'h09 || o_op == 5'h0A) |->
		o_clocks[1:0] == 2'h0)
		else $error("port output count wrong");
	AST_BCD: assert property (o_done && o_op inside {[5'h0D:5'h0F]} |->
		o_flags[14:12] == 3'h3 && o_flags[2:0] == 3'h3 && o_flags[11:9] == 3'h4)
		else $error("packed decimal flags wrong");
	AST_ADJ: assert property (done_np && (o_op == 5'h10 || o_op == 5'h11) |->
		o_clocks[1:0] == 2'h3 && o_flags[11:9] == 3'h4)
		else $error("decimal adjust count or flags wrong");
	AST_CVT: assert property (done_np && (o_op == 5'h12 || o_op == 5'h13) |->
		o_clocks[1:0] == 2'h3 && o_flags[8:0] == 9'h0DB)
		else $error("conversion count or flags wrong");
	AST_LOGIC: assert property (o_hdr_valid && o_op == 5'h14 && o_alu inside {1, 4, 6} |->
		o_flags[14:9] == 6'h09)
		else $error("logical op must clear carry and overflow");
	AST_NO_WR: assert property (o_hdr_valid && o_op == 5'h15 |-> o_no_write)
		else $error("test must not write its destination");
	AST_REG_A: assert property (o_hdr_valid && o_op == 5'h04 |-> o_reg_a[3] == o_wide)
		else $error("immediate load register bank does not follow width");

	// Main scenarios reached
	COV_BLOCK: cover property (o_done && o_op == 5'h05 && o_rep != 3'h0);
	COV_DIRECT: cover property (o_hdr_valid && o_ea == 4'h9);
	COV_GROUP: cover property (o_hdr_valid && o_op == 5'h14 && o_alu == 3'h7);
endmodule

bind cid_decoder cid_decoder_asserts u_chk (.i_clk, .i_reset, .o_hdr_valid, .o_done,
	.o_wide, .o_no_write, .o_op, .o_alu, .o_ea, .o_len, .o_reg_a, .o_reg_b, .o_seg, .o_rep,
	.o_clocks, .o_flags);
`default_nettype wire

// *** cid_mem_model.sv ***
// Instruction memory that streams queued bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module cid_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_ce,
	output logic             o_valid,
	output logic [7:0]       o_byte,
	output logic             o_queued,
	output logic [15:0]      o_count
);
	logic [24:0] fifo[$];  // {count, queued, byte}, filled by the bench
	logic [24:0] e;        // Entry being presented
	logic        taken = 1'b1;  // Enable at the last rising edge: byte accepted

	// The decoder takes a byte only while enabled
	always @(posedge i_clk)
		taken <= i_ce;

	initial begin
		o_valid = 1'b0;
		o_byte = 8'h00;
		o_queued = 1'b0;
		o_count = 16'h0000;
	end

	// Drive off the falling edge; idle lines toggle so stale data never looks valid
	always @(negedge i_clk) begin
		if (o_valid && !taken) begin
			o_valid <= 1'b1;  // Frozen: offer the same byte again
		end else if (fifo.size() != 0) begin
			e = fifo.pop_front();
			o_valid <= 1'b1;
			{o_count, o_queued, o_byte} <= e;
		end else begin
			o_valid <= 1'b0;
			o_byte <= ~o_byte;
			o_queued <= ~o_queued;
			o_count <= ~o_count;
		end
	end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct packed {
		logic [4:0]  op;
		logic [23:0] ck;
		logic [3:0]  len;
		logic [16:0] im;   // Top bit set when checked; loads carry the displacement
	} cid_exp_t;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_ce = 1'b1;   // Random freeze cycles in the second pass
	bit          ce_q = 1'b1;   // Enable seen at the last rising edge
	logic [15:0] o_disp;
	logic        vld;
	logic        qd;
	logic [7:0]  byt;
	logic [15:0] cnt;
	logic [4:0]  o_op;
	logic        o_done;
	logic [23:0] o_clocks;
	logic [15:0] o_imm;
	logic [3:0]  o_bytes;
	int          seed = 32'hafe2_07a8;
	int          err_count = 0;
	int          num_checks = 0;
	bit          rq;            // Random queued flags when set
	cid_exp_t    expq[$];
	cid_exp_t    x;

	always #5 i_clk = ~i_clk;

	// Freeze about one cycle in four while random queue misses run
	always @(negedge i_clk)
		i_ce <= !(rq && ($random(seed) % 4 == 0));

	// A held pulse under freeze is not a new result
	always @(posedge i_clk)
		ce_q <= i_ce;

	cid_mem_model mem_m (.i_clk(i_clk), .i_ce(i_ce), .o_valid(vld), .o_byte(byt),
		.o_queued(qd), .o_count(cnt));
	cid_decoder dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_byte_valid(vld), .i_byte(byt), .i_byte_queued(qd), .i_iter_count(cnt),
		.o_hdr_valid(), .o_op(o_op), .o_alu(), .o_wide(), .o_ea(), .o_len(),
		.o_reg_a(), .o_reg_b(), .o_seg(), .o_rep(), .o_no_write(), .o_done(o_done),
		.o_clocks(o_clocks), .o_disp(o_disp), .o_imm(o_imm), .o_flags(), .o_bytes(o_bytes));

	// One result compare
	task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Queue one instruction's bytes and note its expected result
	task automatic ins(input logic [31:0] b, input int n, input logic [15:0] c,
		input logic [4:0] op, input logic [23:0] ck, input logic [16:0] im);
		logic q;
		int   miss;
		miss = 0;
		for (int i = 0; i < n; i++) begin
			q = rq ? 1'($random(seed)) : 1'b1;
			miss += int'(!q);
			mem_m.fifo.push_back({c, q, b[31-8*i -: 8]});
		end
		expq.push_back('{op, ck + 24'(4 * miss), 4'(n), im});
	endtask

	// Whole instruction table, back to back
	task automatic run_all();
		logic [7:0] r;
		r = 8'($random(seed));
		ins(32'h8AC1_0000, 2, 0, 1, 2, 0);
		ins(32'h8807_0000, 2, 0, 2, 7, 0);
		ins(32'h8B46_0500, 3, 0, 3, 14, 17'h1_0005);
		ins(32'h8A06_3412, 4, 0, 3, 10, 17'h1_1234);
		ins(32'h8A47_F600, 3, 0, 3, 10, 17'h1_FFF6);
		ins({8'hB0, r, 16'h0000}, 2, 0, 4, 4, {9'h100, r});
		ins({8'hB8, r, 16'h1200}, 3, 0, 4, 4, {9'h112, r});
		ins(32'hF3A5_0000, 2, 3, 5, 59, 0);
		ins(32'h64A4_0000, 2, 5, 5, 51, 0);
		ins(32'hA400_0000, 1, 7, 5, 9, 0);
		ins(32'hF2A7_0000, 2, 2, 6, 53, 0);
		ins(32'hA600_0000, 1, 4, 6, 13, 0);
		ins({8'hE4, r, 16'h0000}, 2, 0, 7, 9, 0);
		ins(32'hED00_0000, 1, 0, 8, 12, 0);
		ins({8'hE6, r, 16'h0000}, 2, 0, 9, 8, 0);
		ins(32'hEF00_0000, 1, 0, 10, 12, 0);
		ins(32'h6C00_0000, 1, 0, 11, 10, 0);
		ins(32'h656F_0000, 2, 1, 12, 27, 0);
		ins(32'h0F20_0000, 2, 4, 13, 45, 0);
		ins(32'h0F22_0000, 2, 2, 14, 26, 0);
		ins(32'h0F26_0000, 2, 6, 15, 64, 0);
		ins(32'h2700_0000, 1, 0, 16, 3, 0);
		ins(32'h2F00_0000, 1, 0, 17, 3, 0);
		ins(32'hD40A_0000, 2, 0, 18, 15, 0);
		ins(32'hD50A_0000, 2, 0, 19, 7, 0);
		for (int a = 0; a < 8; a++)
			ins({8'h80, 8'hC3 | 8'(a << 3), r, 8'h00}, 3, 0, 20, 4, {9'h100, r});
		ins(32'h83C3_8000, 3, 0, 20, 4, 17'h1_FF80);
		ins(32'h81C3_3412, 4, 0, 20, 4, 17'h1_1234);
		ins(32'h84C0_0000, 2, 0, 21, 2, 0);
	endtask

	// Each completed instruction is matched against the oldest note
	always @(negedge i_clk) begin
		if (o_done === 1'b1 && ce_q) begin
			x = '1;
			if (expq.size() != 0)
				x = expq.pop_front();
			cmp("op", 24'(x.op), 24'(o_op));
			cmp("clocks", x.ck, o_clocks);
			cmp("bytes", 24'(x.len), 24'(o_bytes));
			if (x.im[16] && x.op == 5'h03)
				cmp("disp", 24'(x.im[15:0]), 24'(o_disp));
			else if (x.im[16])
				cmp("imm", 24'(x.im[15:0]), 24'(o_imm));
		end
	end

	// Verdict and end of run
	task automatic close_out();
		$display("Checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Phase 0 all bytes queued, phase 1 random queue misses
	initial begin
		rq = 1'b0;
		repeat (6) @(negedge i_clk);
		i_reset = 1'b0;
		for (int p = 0; p < 2; p++) begin
			@(posedge i_clk);
			rq = (p == 1);
			run_all();
			for (int t = 0; t < 3000 && expq.size() != 0; t++)
				@(negedge i_clk);
			if (expq.size() != 0) begin
				err_count++;
				break;
			end
			$display("Test %0d ended", p);
		end
		repeat (4) @(negedge i_clk);
		close_out();
	end
endmodule
`default_nettype wire
